// File: logic/drum_block_transfer_control.v
/*
  drum block transfer controller: apb register slave, bit cell timing,
  rotational position, word transfer to and from host core memory.
  assumes the host memory control runs on pclk and answers each request
  with a one-cycle core_ack.
*/
`timescale 1ns/1ps
`default_nettype none
`include "drum_map.vh"

module drum_block_transfer_control #(
  parameter CELL_NS = `CELL_TIME_NS
) (
  input  wire                pclk,
  input  wire                presetn,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [7:0]          paddr,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output wire                pready,
  output wire                pslverr,
  output wire                break_req,
  output wire                break_mode,
  output wire                core_dir,
  output wire [`CORE_W-1:0]  core_addr,
  input  wire                core_ack,
  input  wire [`DATA_W-1:0]  bus_in,
  output wire [`DATA_W-1:0]  bus_out,
  output wire                bus_oe,
  output wire                done_flag,
  output wire                error_flag
);

  localparam CELL_RAW = CELL_NS / `CLK_PERIOD_NS;
  localparam [31:0] CELL_CYC = (CELL_RAW < 1) ? 1 : CELL_RAW;
  localparam [`CELL_W-1:0] CELL_LAST = CELL_CYC[`CELL_W-1:0] - 1'b1;

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SEEK = 3'b010;
  localparam [2:0] ST_RUN  = 3'b100;

  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a[7:2] == off[7:2]);
    end
  endfunction

  function odd_bit;
    input [`DATA_W-1:0] d;
    begin
      odd_bit = ~(^d);
    end
  endfunction

  reg [2:0]            state_reg;
  reg [`CELL_W-1:0]    cell_cnt_reg;
  reg [`LOC_W-1:0]     rotational_position_counter_reg;
  reg [`LOC_W-1:0]     start_storage_location_reg;
  reg [`FIELD_W-1:0]   rd_field_reg;
  reg [`FIELD_W-1:0]   wr_field_reg;
  reg [`CNT_W-1:0]     count_reg;
  reg [`CNT_W-1:0]     remain_reg;
  reg [`CNT_W-1:0]     fetch_left_reg;
  reg [1:0]            mode_reg;
  reg [`CORE_W-1:0]    rd_caddr_reg;
  reg [`CORE_W-1:0]    wr_caddr_reg;
  reg [1:0]            ctrl_reg;
  reg [31:0]           field_write_lockout_reg;
  reg                  done_reg;
  reg                  error_reg;
  reg                  par_err_reg;
  reg                  wlate_reg;
  reg                  rlate_reg;
  reg                  ph2_reg;
  reg [`LOC_W-1:0]     loc_hold_reg;
  reg [`DATA_W-1:0]    wbuf_reg;
  reg                  wbuf_full_reg;
  reg                  rd_pend_reg;
  reg [`DATA_W-1:0]    bus_out_reg;

  wire                 tick;
  wire                 idle;
  wire                 has_rd;
  wire                 has_wr;
  wire                 pos_match;
  wire                 word_tick;
  wire                 late_w;
  wire                 late_r;
  wire                 wr_need;
  wire                 wr_locked;
  wire                 wr_strobe;
  wire                 rd_bad;
  wire                 mapped;
  wire                 wr_en;
  wire                 host_io_transfer_pulse;
  wire                 finish;
  wire [`WORD_W-1:0]   mem_rdata;
  wire [`WORD_W-1:0]   mem_wdata;
  wire [16:0]          mem_addr;
  reg  [31:0]          rd_mux;

  assign idle      = state_reg[0];
  assign has_rd    = mode_reg[0];
  assign has_wr    = mode_reg[1];
  assign tick      = (cell_cnt_reg == CELL_LAST);
  assign pos_match = (rotational_position_counter_reg == start_storage_location_reg);
  // first word waits for the start location to come round
  assign word_tick = tick & (remain_reg != {`CNT_W{1'b0}}) &
                     ((state_reg[1] & pos_match) | state_reg[2]);
  // write data must be buffered before its cell, read store done before the next
  assign late_w    = word_tick & has_wr & ~wbuf_full_reg;
  assign late_r    = tick & state_reg[2] & rd_pend_reg;
  assign rd_bad    = ph2_reg & has_rd & ~(^mem_rdata);
  assign wr_locked = field_write_lockout_reg[wr_field_reg];
  assign wr_strobe = ph2_reg & has_wr & ~wr_locked;
  assign finish    = state_reg[2] & (remain_reg == {`CNT_W{1'b0}}) &
                     ~ph2_reg & ~rd_pend_reg;
  assign wr_need   = ~idle & has_wr & ~wbuf_full_reg &
                     (fetch_left_reg != {`CNT_W{1'b0}});

  // cell n: read strobe on the read field; cell n+1: write strobe
  assign mem_addr  = ph2_reg ? {wr_field_reg, loc_hold_reg}
                             : {rd_field_reg, rotational_position_counter_reg};
  assign mem_wdata = {odd_bit(wbuf_reg) ^ ctrl_reg[`CTRL_BADPAR_BIT], wbuf_reg};

  drum_store #(
    .AW (`FIELD_W + `LOC_W),
    .DW (`WORD_W)
  ) u_store (
    .clk   (pclk),
    .we    (wr_strobe),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  // host side: store read words first, then fetch write data
  assign break_req  = rd_pend_reg | wr_need;
  assign break_mode = ctrl_reg[`CTRL_SBRK_BIT];
  assign core_dir   = rd_pend_reg;
  assign core_addr  = rd_pend_reg ? rd_caddr_reg : wr_caddr_reg;
  assign bus_out    = bus_out_reg;
  assign bus_oe     = rd_pend_reg;
  assign done_flag  = done_reg;
  assign error_flag = error_reg;

  // apb: zero wait states, read data captured in the setup cycle
  assign pready  = 1'b1;
  assign mapped  = hit(paddr, `OFF_DRUM_ADDR) | hit(paddr, `OFF_WORD_COUNT) |
                   hit(paddr, `OFF_CORE_ADDR) | hit(paddr, `OFF_CTRL) |
                   hit(paddr, `OFF_LOCKOUT) | hit(paddr, `OFF_STATUS) |
                   hit(paddr, `OFF_POSITION);
  assign pslverr = psel & penable & ~mapped;
  assign wr_en   = psel & penable & pwrite & mapped;
  // third instruction of the setup starts the transfer
  assign host_io_transfer_pulse = wr_en & hit(paddr, `OFF_CORE_ADDR) & idle;

  always @* begin
    rd_mux = 32'h0000_0000;
    if (hit(paddr, `OFF_DRUM_ADDR)) begin
      rd_mux = {10'h000, wr_field_reg, rd_field_reg, start_storage_location_reg};
    end else if (hit(paddr, `OFF_WORD_COUNT)) begin
      rd_mux = {17'h00000, mode_reg, count_reg};
    end else if (hit(paddr, `OFF_CORE_ADDR)) begin
      rd_mux = {16'h0000, rd_caddr_reg};
    end else if (hit(paddr, `OFF_CTRL)) begin
      rd_mux = {30'h0000_0000, ctrl_reg};
    end else if (hit(paddr, `OFF_LOCKOUT)) begin
      rd_mux = field_write_lockout_reg;
    end else if (hit(paddr, `OFF_STATUS)) begin
      rd_mux = {24'h00_0000,
                1'b0, state_reg[1], rlate_reg, wlate_reg, par_err_reg,
                error_reg, done_reg, ~idle};
    end else if (hit(paddr, `OFF_POSITION)) begin
      rd_mux = {20'h00000, rotational_position_counter_reg};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_mux;
    end
  end

  // setup registers: drum address and word count only loaded while no transfer runs, control and lockout at any time
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_storage_location_reg <= {`LOC_W{1'b0}};
      rd_field_reg               <= {`FIELD_W{1'b0}};
      wr_field_reg               <= {`FIELD_W{1'b0}};
      count_reg                  <= {`CNT_W{1'b0}};
      mode_reg                   <= `MODE_READ;
      ctrl_reg                   <= `CTRL_RST;
      field_write_lockout_reg    <= `LOCKOUT_RST;
    end else if (wr_en) begin
      if (hit(paddr, `OFF_DRUM_ADDR) & idle) begin
        start_storage_location_reg <= pwdata[`DA_LOC_LSB +: `LOC_W];
        rd_field_reg               <= pwdata[`DA_RFIELD_LSB +: `FIELD_W];
        wr_field_reg               <= pwdata[`DA_WFIELD_LSB +: `FIELD_W];
      end
      if (hit(paddr, `OFF_WORD_COUNT) & idle) begin
        count_reg <= pwdata[`CNT_W-1:0];
        mode_reg  <= pwdata[`WC_MODE_LSB +: 2];
      end
      if (hit(paddr, `OFF_CTRL)) begin
        ctrl_reg <= pwdata[1:0];
      end
      if (hit(paddr, `OFF_LOCKOUT)) begin
        field_write_lockout_reg <= pwdata;
      end
    end
  end

  // bit cell timing and drum position; 4096 cells make a revolution
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_cnt_reg                    <= {`CELL_W{1'b0}};
      rotational_position_counter_reg <= {`LOC_W{1'b0}};
    end else if (tick) begin
      cell_cnt_reg                    <= {`CELL_W{1'b0}};
      rotational_position_counter_reg <= rotational_position_counter_reg + 1'b1;
    end else begin
      cell_cnt_reg <= cell_cnt_reg + 1'b1;
    end
  end

  // transfer sequencing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= ST_IDLE;
      remain_reg     <= {`CNT_W{1'b0}};
      fetch_left_reg <= {`CNT_W{1'b0}};
      rd_caddr_reg   <= {`CORE_W{1'b0}};
      wr_caddr_reg   <= {`CORE_W{1'b0}};
      ph2_reg        <= 1'b0;
      loc_hold_reg   <= {`LOC_W{1'b0}};
      wbuf_reg       <= {`DATA_W{1'b0}};
      wbuf_full_reg  <= 1'b0;
      rd_pend_reg    <= 1'b0;
      bus_out_reg    <= {`DATA_W{1'b0}};
    end else begin
      ph2_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (host_io_transfer_pulse) begin
            rd_caddr_reg   <= pwdata[`CORE_W-1:0];
            wr_caddr_reg   <= pwdata[`CORE_W-1:0];
            remain_reg     <= count_reg;
            fetch_left_reg <= count_reg;
            wbuf_full_reg  <= 1'b0;
            rd_pend_reg    <= 1'b0;
            state_reg      <= (count_reg == {`CNT_W{1'b0}}) ? ST_RUN : ST_SEEK;
          end
        end
        ST_SEEK, ST_RUN: begin
          if (late_w | late_r | rd_bad) begin
            // halt at once; pending host traffic is dropped
            state_reg     <= ST_IDLE;
            rd_pend_reg   <= 1'b0;
            wbuf_full_reg <= 1'b0;
          end else if (finish) begin
            state_reg <= ST_IDLE;
          end else begin
            if (word_tick) begin
              state_reg    <= ST_RUN;
              ph2_reg      <= 1'b1;
              loc_hold_reg <= rotational_position_counter_reg;
            end
            if (ph2_reg) begin
              remain_reg <= remain_reg - 1'b1;
              if (has_wr) begin
                wbuf_full_reg <= 1'b0;
              end
              if (has_rd) begin
                bus_out_reg <= mem_rdata[`DATA_W-1:0];
                rd_pend_reg <= 1'b1;
              end
            end else if (core_ack & rd_pend_reg) begin
              rd_pend_reg  <= 1'b0;
              rd_caddr_reg <= rd_caddr_reg + 1'b1;
            end else if (core_ack & wr_need) begin
              wbuf_reg       <= bus_in;
              wbuf_full_reg  <= 1'b1;
              wr_caddr_reg   <= wr_caddr_reg + 1'b1;
              fetch_left_reg <= fetch_left_reg - 1'b1;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // flags: hardware set wins over a software clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg    <= 1'b0;
      error_reg   <= 1'b0;
      par_err_reg <= 1'b0;
      wlate_reg   <= 1'b0;
      rlate_reg   <= 1'b0;
    end else begin
      if (host_io_transfer_pulse) begin
        done_reg    <= 1'b0;
        error_reg   <= 1'b0;
        par_err_reg <= 1'b0;
        wlate_reg   <= 1'b0;
        rlate_reg   <= 1'b0;
      end else if (wr_en & hit(paddr, `OFF_STATUS)) begin
        if (pwdata[`ST_DONE_BIT])   done_reg    <= 1'b0;
        if (pwdata[`ST_ERROR_BIT])  error_reg   <= 1'b0;
        if (pwdata[`ST_PARITY_BIT]) par_err_reg <= 1'b0;
        if (pwdata[`ST_WLATE_BIT])  wlate_reg   <= 1'b0;
        if (pwdata[`ST_RLATE_BIT])  rlate_reg   <= 1'b0;
      end
      if (~idle & finish & ~late_r) begin
        done_reg <= 1'b1;
      end
      if (~idle & (late_w | late_r | rd_bad)) begin
        error_reg <= 1'b1;
      end
      if (~idle & rd_bad) begin
        par_err_reg <= 1'b1;
      end
      if (~idle & late_w) begin
        wlate_reg <= 1'b1;
      end
      if (~idle & late_r) begin
        rlate_reg <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// File: pkg/drum_map.vh
/*
  register offsets, field layouts, reset values and timing for the drum
  transfer controller. assumes a 40 mhz apb clock and byte addresses.
*/
`ifndef DRUM_MAP_VH
`define DRUM_MAP_VH

`define FIELD_COUNT      32
`define FIELD_W          5
`define LOC_W            12
`define DATA_W           18
`define WORD_W           19
`define CNT_W            13
`define CORE_W           16
`define CELL_W           16

`define CLK_PERIOD_NS    25
`define CELL_TIME_NS     8500
`define REV_TIME_MS      35

`define OFF_DRUM_ADDR    8'h00
`define OFF_WORD_COUNT   8'h04
`define OFF_CORE_ADDR    8'h08
`define OFF_CTRL         8'h0c
`define OFF_LOCKOUT      8'h10
`define OFF_STATUS       8'h14
`define OFF_POSITION     8'h18

`define DA_LOC_LSB       0
`define DA_RFIELD_LSB    12
`define DA_WFIELD_LSB    17
`define WC_MODE_LSB      13

`define MODE_READ        2'h1
`define MODE_WRITE       2'h2
`define MODE_EXCH        2'h3

`define CTRL_SBRK_BIT    0
`define CTRL_BADPAR_BIT  1

`define ST_ACTIVE_BIT    0
`define ST_DONE_BIT      1
`define ST_ERROR_BIT     2
`define ST_PARITY_BIT    3
`define ST_WLATE_BIT     4
`define ST_RLATE_BIT     5
`define ST_SEEK_BIT      6

`define CTRL_RST         2'h0
`define LOCKOUT_RST      32'h0000_0000

`endif

// File: logic/drum_store.v
/*
  single port word store standing in for the drum surface.
  assumes one access per cycle; read data is registered.
*/
`timescale 1ns/1ps
`default_nettype none

module drum_store #(
  parameter AW = 17,
  parameter DW = 19
) (
  input  wire          clk,
  input  wire          we,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  output reg  [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // read before write on the same port: old contents come back
  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

`default_nettype wire

// File: verif/host_mem_model.sv
/*
  host core memory control model: answers each break request after lat
  cycles with a one-cycle core_ack. assumes one pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "drum_map.vh"
module host_mem_model (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               break_req,
  input  wire logic               core_dir,
  input  wire logic [`CORE_W-1:0] core_addr,
  input  wire logic [`DATA_W-1:0] bus_out,
  input  wire logic [7:0]         lat,
  output var  logic               core_ack,
  output var  logic [`DATA_W-1:0] bus_in
);
  logic [`DATA_W-1:0] mem [0:63];
  logic [7:0]         cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ack <= 1'b0;
      cnt      <= 8'h00;
      bus_in   <= 18'h15555;
    end else if (core_ack) begin
      core_ack <= 1'b0;
      cnt      <= 8'h00;
      bus_in   <= ~bus_in;
    end else if (break_req && cnt >= lat) begin
      // store and fetch are whole 18-bit words
      core_ack <= 1'b1;
      if (core_dir)
        mem[core_addr[5:0]] <= bus_out;
      else
        bus_in <= mem[core_addr[5:0]];
    end else if (break_req) begin
      // a long lat is how late data is provoked
      cnt <= cnt + 8'h01;
    end else begin
      // no stale value on an idle bus
      bus_in <= ~bus_in;
    end
  end
endmodule
`default_nettype wire

// File: verif/drum_xfer_asserts.sv
/*
  port checker for the drum transfer controller, bound to its top module.
  assumes the byte offsets of drum_map.vh.
*/
`timescale 1ns/1ps
`default_nettype none
`include "drum_map.vh"
module drum_xfer_asserts (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pslverr,
  input wire logic               break_req,
  input wire logic               break_mode,
  input wire logic               core_dir,
  input wire logic [`CORE_W-1:0] core_addr,
  input wire logic               core_ack,
  input wire logic [`DATA_W-1:0] bus_out,
  input wire logic               bus_oe,
  input wire logic               done_flag,
  input wire logic               error_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_slverr_unmapped: assert property (psel && penable && paddr > 8'h1b |-> pslverr)
    else $error("unmapped access without slave error");
  a_slverr_mapped: assert property (psel && penable && paddr == `OFF_STATUS |-> !pslverr)
    else $error("status access gave slave error");
  a_unmapped_zero: assert property (psel && !penable && !pwrite && paddr > 8'h1b |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_status_flags: assert property (psel && !penable && !pwrite && paddr == `OFF_STATUS
    |=> prdata[2:1] == $past({error_flag, done_flag}))
    else $error("status flags differ from flag outputs");
  a_mode_follow: assert property (psel && penable && pwrite && paddr == `OFF_CTRL
    |=> break_mode == $past(pwdata[0]))
    else $error("break mode not taken from control");
  a_oe_dir: assert property (bus_oe == core_dir)
    else $error("bus enable disagrees with direction");
  a_req_hold: assert property (break_req && !core_ack ##1 !error_flag
    |-> break_req && $stable(core_addr) && $stable(core_dir))
    else $error("request changed before acknowledge");
  a_data_hold: assert property (break_req && core_dir && !core_ack ##1 !error_flag |-> $stable(bus_out))
    else $error("store data changed before acknowledge");
  a_error_quiet: assert property (error_flag |-> !break_req)
    else $error("request while halted on error");
  a_done_quiet: assert property (done_flag |-> !break_req && !error_flag)
    else $error("request or error while done");
endmodule
bind drum_block_transfer_control drum_xfer_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .break_req(break_req), .break_mode(break_mode), .core_dir(core_dir), .core_addr(core_addr),
  .core_ack(core_ack), .bus_out(bus_out), .bus_oe(bus_oe), .done_flag(done_flag), .error_flag(error_flag));
`default_nettype wire

// File: verif/testbench.sv
/*
  self-checking bench: apb tasks set up transfers, host model moves words.
  assumes a 10-cycle bit cell (CELL_NS 250) to keep runs short; writes are
  read back one drum turn later, so the run spans a little over one turn.
*/
`timescale 1ns/1ps
`default_nettype none
`include "drum_map.vh"
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0] paddr = 8'h00, lat = 8'h02;
  logic [11:0] la, lb, lc, ld, lp;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, break_req, break_mode, core_dir, core_ack, bus_oe, done_flag, error_flag;
  logic [`CORE_W-1:0] core_addr;
  logic [`DATA_W-1:0] bus_in, bus_out;
  integer miscompares = 0, compares = 0, i;
  always #12.5 pclk = ~pclk;
  drum_block_transfer_control #(.CELL_NS(250)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .break_req(break_req), .break_mode(break_mode), .core_dir(core_dir),
    .core_addr(core_addr), .core_ack(core_ack), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
    .done_flag(done_flag), .error_flag(error_flag));
  host_mem_model host_u (.pclk(pclk), .presetn(presetn), .break_req(break_req), .core_dir(core_dir),
    .core_addr(core_addr), .bus_out(bus_out), .lat(lat), .core_ack(core_ack), .bus_in(bus_in));
  function [17:0] w(input integer k);
    w = 18'h0a5a5 + k[17:0] * 18'h01234;
  endfunction
  task finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] x);
    compares = compares + 1;
    if (g !== x) begin
      miscompares = miscompares + 1;
      $display("[FAIL] %0t got %h expected %h", $time, g, x);
    end
  endtask
  task apb(input wr, input [7:0] a, input [31:0] d, output [31:0] r, output e);
    integer k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k = k + 1;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k >= 50) begin
      miscompares = miscompares + 1;
      finish_test();
    end
  endtask
  task xfer(input [1:0] md, input [4:0] rf, input [4:0] wf, input [12:0] n, input [15:0] ca, input [11:0] loc);
    integer k;
    apb(1, `OFF_DRUM_ADDR, {10'h0, wf, rf, loc}, rd, er);
    apb(1, `OFF_WORD_COUNT, {17'h0, md, n}, rd, er);
    apb(1, `OFF_CORE_ADDR, {16'h0, ca}, rd, er);
    k = 0;
    // a location just passed costs a whole turn of 4096 cells
    while (done_flag !== 1'b1 && error_flag !== 1'b1 && k < 45000) begin
      @(negedge pclk);
      k = k + 1;
    end
    @(posedge pclk);
    if (k >= 45000) begin
      miscompares = miscompares + 1;
      finish_test();
    end
  endtask
  task ahead(output [11:0] l);
    // margin of eight cells covers the setup writes that follow
    apb(0, `OFF_POSITION, 0, rd, er);
    l = rd[11:0] + 12'h008;
  endtask
  task stat(input [31:0] x);
    apb(0, `OFF_STATUS, 0, rd, er);
    chk(rd & 32'h3e, x);
  endtask
  initial begin
    // drum surface starts as zero words with good parity
    for (i = 0; i < 131072; i = i + 1) dut_u.u_store.mem[i] = 19'h40000;
    for (i = 0; i < 64; i = i + 1) host_u.mem[i] = 18'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    stat(0);
    apb(0, `OFF_LOCKOUT, 0, rd, er); chk(rd, 0);
    apb(0, 8'h1c, 0, rd, er); chk({rd[30:0], er}, 1);
    apb(1, `OFF_CTRL, 1, rd, er); chk(break_mode, 1);
    $display("test registers done");
    // first turn: writes at spaced locations, read back on the next turn
    for (i = 0; i < 3; i = i + 1) host_u.mem[i] = w(i);
    ahead(la); xfer(`MODE_WRITE, 0, 3, 3, 0, la); chk(done_flag, 1);
    stat(32'h2);
    apb(1, `OFF_LOCKOUT, 32'h10, rd, er);
    for (i = 0; i < 3; i = i + 1) host_u.mem[8 + i] = ~w(i);
    ahead(lb); xfer(`MODE_WRITE, 0, 4, 3, 8, lb); chk(error_flag, 0);
    apb(1, `OFF_LOCKOUT, 0, rd, er);
    for (i = 0; i < 3; i = i + 1) host_u.mem[32 + i] = ~w(i);
    ahead(lc); xfer(`MODE_EXCH, 5, 6, 3, 32, lc); chk(done_flag, 1);
    for (i = 0; i < 3; i = i + 1) chk(host_u.mem[32 + i], 0);
    apb(1, `OFF_CTRL, 2, rd, er);
    ahead(ld); xfer(`MODE_WRITE, 0, 7, 1, 0, ld);
    apb(1, `OFF_CTRL, 0, rd, er);
    $display("test first turn done");
    xfer(`MODE_READ, 3, 0, 3, 16, la); chk(error_flag, 0);
    for (i = 0; i < 3; i = i + 1) chk(host_u.mem[16 + i], w(i));
    xfer(`MODE_READ, 4, 0, 3, 24, lb);
    for (i = 0; i < 3; i = i + 1) chk(host_u.mem[24 + i], 0);
    xfer(`MODE_READ, 6, 0, 3, 40, lc);
    for (i = 0; i < 3; i = i + 1) chk(host_u.mem[40 + i], w(i) ^ 18'h3ffff);
    xfer(`MODE_READ, 7, 0, 1, 48, ld); chk(error_flag, 1);
    stat(32'h0c);
    apb(1, `OFF_STATUS, 32'h3e, rd, er);
    stat(0);
    $display("test second turn done");
    // host answers far slower than the seek and the bit cell
    lat <= 8'hc8;
    ahead(lp); xfer(`MODE_WRITE, 0, 8, 1, 0, lp);
    stat(32'h14);
    ahead(lp); xfer(`MODE_READ, 3, 0, 2, 56, lp);
    stat(32'h24);
    $display("test late data done");
    finish_test();
  end
endmodule
`default_nettype wire
